// ==== common/gate_if.sv ====
// Handshake between the clock generator and one stop-input gating unit.
`timescale 1ns/1ps
interface gate_if;
  logic boundary;
  logic run;
  modport ctrl (output boundary, input run);
  modport unit (input boundary, output run);
endinterface : gate_if

// ==== common/stop_clock_pkg.sv ====
// Constants shared by the stop-clock gating control design.
package stop_clock_pkg;

  // Register offsets on the byte-wide configuration port.
  localparam logic [2:0] REG_MEM_EN_OFFSET = 3'h4;
  localparam logic [2:0] REG_SPARE_OFFSET = 3'h6;

  // Power-up defaults and the answer to an unmapped read.
  localparam logic [7:0] MEM_EN_RESET = 8'hff;
  localparam logic [7:0] SPARE_RESET = 8'hff;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Field layout of the memory clock enable register, and the bus clock and strap pin counts.
  localparam int MEM_EN_LSB = 0;
  localparam int MEM_CLK_COUNT = 4;
  localparam int BUS_CLK_COUNT = 6;
  localparam int STRAP_COUNT = 4;

  // Clock generation: processor clock is clk/2, bus clock clk/4.
  localparam logic PROC_PHASE_RESET = 1'b0;
  localparam logic [1:0] BUS_CNT_RESET = 2'h0;
  localparam logic [1:0] BUS_CNT_LAST = 2'h3;
  localparam int BUS_HIGH_BIT = 1;

  // Timing figures in processor or bus clock cycles and their clk equivalents.
  localparam int CLK_PER_PROC_CYCLE = 2;
  localparam int CLK_PER_BUS_CYCLE = 4;
  localparam int PROC_MIN_RUN_CYCLES = 100;
  localparam int PROC_LATENCY_LIMIT_CYCLES = 4;
  localparam int BUS_MIN_RUN_CYCLES = 10;
  localparam int PROC_MIN_RUN_CLKS = PROC_MIN_RUN_CYCLES * CLK_PER_PROC_CYCLE;
  localparam int BUS_MIN_RUN_CLKS = BUS_MIN_RUN_CYCLES * CLK_PER_BUS_CYCLE;

  // Strap sampling window after reset release, in clk cycles.
  localparam logic [1:0] STRAP_SETTLE_RESET = 2'h0;
  localparam logic [1:0] STRAP_SETTLE_LAST = 2'h3;
  localparam logic [3:0] STRAP_SYNC_RESET = 4'h0;

  // Stop synchroniser reset level: clocks run.
  localparam logic STOP_SYNC_RESET = 1'b1;
  localparam logic RUN_RESET = 1'b1;

endpackage : stop_clock_pkg

// ==== core/stop_clock_gating_control.sv ====
// Output gating of the processor, bus and upper memory clocks with strap capture.
// Functional notes
// - Memory enable register, bits 3..0, reset ones.
// - Disabled memory clock held low, no switching.
// - Spare register reads ones, writes ignored.
// - Processor stop input synchronised before gating.
// - Other clocks keep running during processor stop.
// - Processor clock stops low, restarts full high.
// - Processor stop and restart under four cycles.
// - Bus stop synchronised, gates bus clocks 0..5.
// - Bus clocks stop low, restart full high.
// - Bus clocks resume next rise, stop one cycle.
// - Latencies counted on the internal processor clock.
// - Dual-function pins sampled into four-bit latch.
// - After reset pins drive clocks, latch kept.
`timescale 1ns/1ps
module stop_clock_gating_control
  import stop_clock_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic proc_stop_n,
  input wire logic bus_stop_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic processor_clock_out,
  output logic [BUS_CLK_COUNT-1:0] stoppable_bus_clock_out,
  output logic [MEM_CLK_COUNT-1:0] memory_clock_out,
  input wire logic [STRAP_COUNT-1:0] dual_pin_in,
  output logic [STRAP_COUNT-1:0] dual_pin_out,
  output logic [STRAP_COUNT-1:0] dual_pin_oe_n,
  output logic [STRAP_COUNT-1:0] power_up_default
);

  typedef struct packed {
    // Divider state; the stop inputs never reach these two fields.
    logic proc_phase;
    logic [1:0] bus_cnt;
    logic [7:0] mem_en;
    logic [MEM_CLK_COUNT-1:0] mem_gate;
    logic proc_out;
    logic [BUS_CLK_COUNT-1:0] bus_out;
    logic [MEM_CLK_COUNT-1:0] mem_out;
    logic bus_free_out;
    logic [7:0] rdata;
    // Strap capture runs once after each reset.
    logic [1:0] settle_cnt;
    logic straps_done;
    logic [STRAP_COUNT-1:0] strap_sync1;
    logic [STRAP_COUNT-1:0] strap_sync2;
    logic [STRAP_COUNT-1:0] strap_latch;
  } top_state_t;

  top_state_t q;
  top_state_t d;

  gate_if proc_gate ();
  gate_if bus_gate ();

  logic proc_phase_next;
  logic [1:0] bus_cnt_next;
  logic proc_boundary;
  logic bus_boundary;
  logic proc_run;
  logic bus_run;
  logic settle_done;
  logic [MEM_CLK_COUNT-1:0] mem_en_low;
  logic [7:0] read_word;

  // Both stop inputs are sampled and measured on clk, the internal processor reference.
  // Each input has its own unit, so one stop never delays or masks the other.
  stop_sync_gate proc_unit (
    .clk(clk),
    .reset_n(reset_n),
    .stop_n(proc_stop_n),
    .gate(proc_gate.unit)
  );

  stop_sync_gate bus_unit (
    .clk(clk),
    .reset_n(reset_n),
    .stop_n(bus_stop_n),
    .gate(bus_gate.unit)
  );

  // A boundary is the edge after which the clock enters its low phase.
  // The bus count wraps from three to zero, so its boundary falls every fourth clk.
  assign proc_boundary = q.proc_phase;
  assign bus_boundary = (q.bus_cnt == BUS_CNT_LAST);
  assign proc_gate.boundary = proc_boundary;
  assign bus_gate.boundary = bus_boundary;

  // Run levels, enable field and strap timing seen by the next-state logic.
  assign proc_run = proc_gate.run;
  assign bus_run = bus_gate.run;
  assign mem_en_low = q.mem_en[MEM_EN_LSB +: MEM_CLK_COUNT];
  assign settle_done = (q.settle_cnt == STRAP_SETTLE_LAST);

  // Free-running dividers; stop inputs never touch them, so all other clocks run on.
  always_comb begin
    proc_phase_next = ~q.proc_phase;
    bus_cnt_next = q.bus_cnt + 2'h1;
  end

  // Read multiplexer. It sees the stored byte, so a write in the same cycle is not yet visible.
  always_comb begin
    case (reg_addr)
      REG_MEM_EN_OFFSET: begin
        read_word = q.mem_en;
      end
      REG_SPARE_OFFSET: begin
        read_word = SPARE_RESET;
      end
      default: begin
        read_word = UNMAPPED_READ;
      end
    endcase
  end

  always_comb begin
    d = q;
    d.proc_phase = proc_phase_next;
    d.bus_cnt = bus_cnt_next;

    // Processor clock: run changes only at a boundary, so output holds low and the
    // first high phase after restart is a whole one. Worst case is two clk of
    // synchroniser plus two clk to the boundary, well under four processor cycles.
    d.proc_out = proc_phase_next & proc_run;

    // Bus clocks: high in the upper half of the four-clk count, gated the same way.
    for (int i = 0; i < BUS_CLK_COUNT; i++) begin
      d.bus_out[i] = bus_cnt_next[BUS_HIGH_BIT] & bus_run;
    end
    d.bus_free_out = bus_cnt_next[BUS_HIGH_BIT];

    // Memory enables are taken at a processor boundary so a change mid-phase cannot clip a pulse.
    if (proc_boundary) begin
      d.mem_gate = mem_en_low;
    end
    // Bit i of the field and of memory_clock_out stands for memory clock 8+i.
    for (int i = 0; i < MEM_CLK_COUNT; i++) begin
      d.mem_out[i] = proc_phase_next & d.mem_gate[i];
    end

    // Register writes. Only the low four enable bits steer logic; the upper ones are written and read back but drive nothing.
    if (reg_wr_en) begin
      case (reg_addr)
        REG_MEM_EN_OFFSET: begin
          d.mem_en = reg_wdata;
        end
        REG_SPARE_OFFSET: begin
          // The spare byte takes the write and stores nothing, so it always reads back ones.
          d.mem_en = q.mem_en;
        end
        default: begin
          d.mem_en = q.mem_en;
        end
      endcase
    end

    // Register reads, answered one cycle after the strobe.
    if (reg_rd_en) begin
      d.rdata = read_word;
    end

    // Strap capture: the pins stay inputs while the settle count runs after reset, then
    // the synchronised level is latched once and the pins turn into clock outputs.
    d.strap_sync1 = dual_pin_in;
    d.strap_sync2 = q.strap_sync1;
    if (!q.straps_done) begin
      if (settle_done) begin
        d.strap_latch = q.strap_sync2;
        d.straps_done = 1'b1;
      end else begin
        d.settle_cnt = q.settle_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // Reset puts every clock low, so the first high phase after release is a whole one.
      q.proc_phase <= PROC_PHASE_RESET;
      q.bus_cnt <= BUS_CNT_RESET;
      q.mem_en <= MEM_EN_RESET;
      q.mem_gate <= MEM_EN_RESET[MEM_EN_LSB +: MEM_CLK_COUNT];
      q.proc_out <= 1'b0;
      q.bus_out <= '0;
      q.mem_out <= '0;
      q.bus_free_out <= 1'b0;
      q.rdata <= UNMAPPED_READ;
      q.settle_cnt <= STRAP_SETTLE_RESET;
      q.straps_done <= 1'b0;
      q.strap_sync1 <= STRAP_SYNC_RESET;
      q.strap_sync2 <= STRAP_SYNC_RESET;
      q.strap_latch <= STRAP_SYNC_RESET;
    end else begin
      q <= d;
    end
  end

  // Output drive. The latch is never rewritten after capture, so the values are kept.
  // The pins turn round once per reset, so the clock they carry later cannot reach the latch.
  always_comb begin
    reg_rdata = q.rdata;
    processor_clock_out = q.proc_out;
    stoppable_bus_clock_out = q.bus_out;
    memory_clock_out = q.mem_out;
    power_up_default = q.strap_latch;
    // The pins carry the free bus clock once straps are taken; the enable is active low.
    for (int i = 0; i < STRAP_COUNT; i++) begin
      dual_pin_out[i] = q.straps_done & q.bus_free_out;
      dual_pin_oe_n[i] = ~q.straps_done;
    end
  end

endmodule : stop_clock_gating_control

// ==== core/stop_sync_gate.sv ====
// Synchroniser and low-phase run latch for one asynchronous stop input.
`timescale 1ns/1ps
module stop_sync_gate
  import stop_clock_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic stop_n,
  gate_if.unit gate
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic run;
  } unit_state_t;

  unit_state_t q;
  unit_state_t d;

  always_comb begin
    d = q;
    d.sync1 = stop_n;
    d.sync2 = q.sync1;
    // The run level only moves at a boundary whose next phase is low, so no runt pulse appears.
    if (gate.boundary) begin
      d.run = q.sync2;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q.sync1 <= STOP_SYNC_RESET;
      q.sync2 <= STOP_SYNC_RESET;
      q.run <= RUN_RESET;
    end else begin
      q <= d;
    end
  end

  assign gate.run = q.run;

endmodule : stop_sync_gate

// ==== verification/power_mgmt_model.sv ====
// Power-management partner that drives both stop inputs.
`timescale 1ns/1ps
module power_mgmt_model
  import stop_clock_pkg::*;
(
  input wire logic clk,
  input wire logic proc_req_n,
  input wire logic bus_req_n,
  output logic proc_stop_n,
  output logic bus_stop_n
);
  int proc_run = 0;
  int bus_run = 0;
  initial begin
    proc_stop_n = 1'b1;
    bus_stop_n = 1'b1;
  end
  // A stop request is held back until the clocks have run their minimum time.
  always @(negedge clk) begin
    proc_run = proc_stop_n ? proc_run + 1 : 0;
    bus_run = bus_stop_n ? bus_run + 1 : 0;
    if (proc_req_n || proc_run >= PROC_MIN_RUN_CLKS) begin
      proc_stop_n <= proc_req_n;
    end
    if (bus_req_n || bus_run >= BUS_MIN_RUN_CLKS) begin
      bus_stop_n <= bus_req_n;
    end
  end
endmodule : power_mgmt_model

// ==== verification/stop_clock_gating_control_props.sv ====
// Port-level assertions for the stop-clock gating control.
`timescale 1ns/1ps
module stop_clock_props
  import stop_clock_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic proc_stop_n,
  input wire logic bus_stop_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic processor_clock_out,
  input wire logic [BUS_CLK_COUNT-1:0] stoppable_bus_clock_out,
  input wire logic [MEM_CLK_COUNT-1:0] memory_clock_out,
  input wire logic [STRAP_COUNT-1:0] dual_pin_in,
  input wire logic [STRAP_COUNT-1:0] dual_pin_oe_n,
  input wire logic [STRAP_COUNT-1:0] power_up_default
);
  logic [7:0] en_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      en_q <= MEM_EN_RESET;
    end else if (reg_wr_en && reg_addr == REG_MEM_EN_OFFSET) begin
      en_q <= reg_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // The windows cover two synchroniser stages plus the wait for a low-phase boundary.
  sequence proc_held_low; !proc_stop_n [*7]; endsequence
  sequence bus_held_high; bus_stop_n [*8] ##1 bus_stop_n [*4]; endsequence
  chk_spare_ones: assert property (reg_rd_en && reg_addr == REG_SPARE_OFFSET |=> reg_rdata == SPARE_RESET)
    else $error("spare read not ones");
  chk_proc_off: assert property (proc_held_low |-> !processor_clock_out)
    else $error("processor clock not stopped");
  chk_proc_on: assert property (proc_stop_n [*8] ##0 $past(reset_n, 3) |-> $changed(processor_clock_out))
    else $error("processor clock not running");
  chk_proc_full_high: assert property (processor_clock_out |=> !processor_clock_out)
    else $error("processor high phase wrong");
  chk_mem_runs: assert property ((!processor_clock_out && en_q[0] && $past(en_q[0], 4)) [*3]
    |-> $changed(memory_clock_out[0])) else $error("memory clock halted");
  chk_bus_off: assert property (!bus_stop_n [*8] |-> stoppable_bus_clock_out == 6'h00)
    else $error("bus clocks not stopped");
  chk_bus_on: assert property (bus_held_high ##0 $past(reset_n, 8)
    |-> stoppable_bus_clock_out == ~$past(stoppable_bus_clock_out, 2)) else $error("bus clocks not running");
  chk_strap_latch: assert property ($fell(dual_pin_oe_n[0]) |-> power_up_default == $past(dual_pin_in, 3))
    else $error("strap latch wrong");
endmodule : stop_clock_props
bind stop_clock_gating_control stop_clock_props u_stop_clock_props (
  .clk(clk),
  .reset_n(reset_n),
  .proc_stop_n(proc_stop_n),
  .bus_stop_n(bus_stop_n),
  .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .processor_clock_out(processor_clock_out),
  .stoppable_bus_clock_out(stoppable_bus_clock_out),
  .memory_clock_out(memory_clock_out),
  .dual_pin_in(dual_pin_in),
  .dual_pin_oe_n(dual_pin_oe_n),
  .power_up_default(power_up_default)
);

// ==== verification/tb_stop_clock_gating_control.sv ====
// Self-checking bench for the stop-clock gating control.
`timescale 1ns/1ps
module tb_stop_clock_gating_control import stop_clock_pkg::*;;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic proc_req_n = 1'b1;
  logic bus_req_n = 1'b1;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [STRAP_COUNT-1:0] dual_pin_in = 4'ha;
  logic proc_stop_n, bus_stop_n, processor_clock_out;
  logic [7:0] reg_rdata, p, b, m, g, f;
  logic [BUS_CLK_COUNT-1:0] stoppable_bus_clock_out;
  logic [MEM_CLK_COUNT-1:0] memory_clock_out;
  logic [STRAP_COUNT-1:0] dual_pin_out, dual_pin_oe_n, power_up_default;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  power_mgmt_model u_power_mgmt_model (
    .clk(clk),
    .proc_req_n(proc_req_n),
    .bus_req_n(bus_req_n),
    .proc_stop_n(proc_stop_n),
    .bus_stop_n(bus_stop_n)
  );
  stop_clock_gating_control u_stop_clock_gating_control (
    .clk(clk),
    .reset_n(reset_n),
    .proc_stop_n(proc_stop_n),
    .bus_stop_n(bus_stop_n),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .processor_clock_out(processor_clock_out),
    .stoppable_bus_clock_out(stoppable_bus_clock_out),
    .memory_clock_out(memory_clock_out),
    .dual_pin_in(dual_pin_in),
    .dual_pin_out(dual_pin_out),
    .dual_pin_oe_n(dual_pin_oe_n),
    .power_up_default(power_up_default)
  );
  task check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask : wr
  task rd(input logic [2:0] a, input logic [7:0] exp, input string n);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    @(negedge clk);
    check(n, reg_rdata, exp);
  endtask : rd
  // Counts high samples over eight cycles: a clk/2 clock gives 4, clk/4 gives 4, a stopped one 0.
  task sample;
    p = 8'h00;
    b = 8'h00;
    m = 8'h00;
    g = 8'h00;
    f = 8'h00;
    repeat (8) begin
      @(negedge clk);
      p += 8'(processor_clock_out);
      b += 8'(stoppable_bus_clock_out[5]);
      m += 8'(memory_clock_out[0]);
      g += 8'(memory_clock_out[3]);
      f += 8'(dual_pin_out[0]);
    end
  endtask : sample
  task strap_scn;
    repeat (8) @(negedge clk);
    dual_pin_in = 4'h5;
    repeat (4) @(negedge clk);
    check("straps", 8'(power_up_default), 8'h0a);
    check("pin_oe_n", 8'(dual_pin_oe_n), 8'h00);
    sample();
    check("strap_pin_clock", f, 8'h04);
  endtask : strap_scn
  task reg_scn;
    rd(REG_MEM_EN_OFFSET, MEM_EN_RESET, "mem_en_reset");
    rd(REG_SPARE_OFFSET, SPARE_RESET, "spare_reset");
    wr(REG_SPARE_OFFSET, 8'h00);
    rd(REG_SPARE_OFFSET, SPARE_RESET, "spare_written");
    wr(3'h1, 8'h00);
    rd(REG_MEM_EN_OFFSET, MEM_EN_RESET, "mem_en_kept");
    rd(3'h1, UNMAPPED_READ, "unmapped");
  endtask : reg_scn
  task mem_scn;
    wr(REG_MEM_EN_OFFSET, 8'h0e);
    rd(REG_MEM_EN_OFFSET, 8'h0e, "mem_en_written");
    sample();
    check("mem8_off", m, 8'h00);
    check("mem11_on", g, 8'h04);
    wr(REG_MEM_EN_OFFSET, 8'hff);
    repeat (4) @(negedge clk);
    sample();
    check("mem8_on", m, 8'h04);
  endtask : mem_scn
  task proc_scn;
    proc_req_n = 1'b0;
    repeat (300) if (proc_stop_n) @(negedge clk);
    repeat (8) @(negedge clk);
    sample();
    check("proc_stopped", p, 8'h00);
    check("bus_in_proc_stop", b, 8'h04);
    check("mem_in_proc_stop", m, 8'h04);
    proc_req_n = 1'b1;
    repeat (8) @(negedge clk);
    sample();
    check("proc_restarted", p, 8'h04);
  endtask : proc_scn
  task bus_scn;
    bus_req_n = 1'b0;
    repeat (300) if (bus_stop_n) @(negedge clk);
    repeat (8) @(negedge clk);
    sample();
    check("bus_stopped", b, 8'h00);
    check("proc_in_bus_stop", p, 8'h04);
    check("bus_all_low", 8'(stoppable_bus_clock_out), 8'h00);
    bus_req_n = 1'b1;
    repeat (8) @(negedge clk);
    sample();
    check("bus_restarted", b, 8'h04);
  endtask : bus_scn
  task wrap_up;
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    strap_scn();
    reg_scn();
    mem_scn();
    proc_scn();
    bus_scn();
    wrap_up();
  end
endmodule : tb_stop_clock_gating_control
